// file: rtl/qsp_pkg.sv
// shared types and constants of the quad serial master channel
package qsp_pkg;

   // ==========================================================
   // transfer line modes
   localparam logic [1:0] QSP_LINES_SINGLE = 2'h0;
   localparam logic [1:0] QSP_LINES_DUAL   = 2'h1;
   localparam logic [1:0] QSP_LINES_QUAD   = 2'h2;

   localparam logic [3:0] QSP_OE_SINGLE    = 4'h1;
   localparam logic [3:0] QSP_OE_DUAL      = 4'h3;
   localparam logic [3:0] QSP_OE_QUAD      = 4'hf;
   localparam logic [3:0] QSP_OE_NONE      = 4'h0;

   // ==========================================================
   // reset values
   localparam logic       QSP_TX_EMPTY_RST = 1'b1;
   localparam logic       QSP_FLAG_RST     = 1'b0;
   localparam logic [4:0] QSP_CNT_RST      = 5'h00;

   // ==========================================================
   // defaults for sizing
   localparam int QSP_DATA_W     = 16;
   localparam int QSP_FIFO_DEPTH = 8;

   // ==========================================================
   // mode configuration
   typedef struct packed {
      logic       input_pull_enable;
      logic       master_clock_nodivide;
      logic       low_bit_first;
      logic       clock_phase_sel;
      logic       clock_polarity_sel;
      logic       master_select;
      logic [1:0] line_count_mode;
      logic [3:0] char_clock_count;
      logic [3:0] drive_clock_count;
   } qsp_mode_t;

   // memory mapped read configuration, held only
   typedef struct packed {
      logic [3:0]  select_negate_period;
      logic [11:0] remap_base;
      logic [3:0]  dummy_drive_length;
      logic [3:0]  dummy_length;
      logic [1:0]  data_phase_lines;
      logic [1:0]  dummy_phase_lines;
      logic [1:0]  addr_phase_lines;
      logic        addr_size_sel;
      logic [7:0]  xip_enter_byte;
      logic [7:0]  xip_exit_byte;
   } qsp_mmap_t;

   // event flags, also used for enables and clears
   typedef struct packed {
      logic tx_empty;
      logic tx_end;
      logic rx_full;
      logic overrun;
   } qsp_flags_t;

   typedef enum logic {
      QSP_ST_IDLE,
      QSP_ST_RUN
   } qsp_state_t;

endpackage

// file: rtl/qsp_master.sv
// quad serial master channel: transmit fifo, shift engine, flags and dma requests

// ==========================================================
// fifo
module qsp_fifo #(
   parameter int WIDTH = 16,
   parameter int DEPTH = 8
) (
   // clock and reset
   input  wire logic             clk,
   input  wire logic             rst_n,
   input  wire logic             flush,
   // fill side
   input  wire logic             in_valid,
   output logic                  in_ready,
   input  wire logic [WIDTH-1:0] in_data,
   // drain side
   output logic                  out_valid,
   input  wire logic             out_ready,
   output logic      [WIDTH-1:0] out_data
);
   localparam int AW = $clog2(DEPTH);
   localparam logic [AW:0] FULL = (AW + 1)'(DEPTH);

   if (DEPTH < 2 || (1 << AW) != DEPTH)
   begin : g_chk
      $error("fifo depth must be a power of two");
   end

   logic [WIDTH-1:0] mem_q [DEPTH];
   logic [AW-1:0]    wr_q;
   logic [AW-1:0]    rd_q;
   logic [AW:0]      cnt_q;
   logic [AW:0]      cnt_d;
   logic             push;
   logic             pop;

   assign push      = in_valid & in_ready;
   assign pop       = out_valid & out_ready;
   assign out_valid = (cnt_q != '0);
   assign out_data  = mem_q[rd_q];

   always_comb
   begin
      cnt_d = cnt_q;
      if (flush)
         cnt_d = '0;
      else if (push & ~pop)
         cnt_d = cnt_q + 1'b1;
      else if (pop & ~push)
         cnt_d = cnt_q - 1'b1;
   end

   always_ff @(posedge clk or negedge rst_n)
   begin
      if (!rst_n)
      begin
         wr_q     <= '0;
         rd_q     <= '0;
         cnt_q    <= '0;
         in_ready <= 1'b1;
      end
      else
      begin
         wr_q     <= flush ? '0 : (push ? wr_q + 1'b1 : wr_q);
         rd_q     <= flush ? '0 : (pop ? rd_q + 1'b1 : rd_q);
         cnt_q    <= cnt_d;
         in_ready <= (cnt_d != FULL);
      end
   end

   // storage needs no reset, only valid entries are read
   always_ff @(posedge clk)
   begin
      if (push)
         mem_q[wr_q] <= in_data;
   end
endmodule // qsp_fifo

// ==========================================================
// channel top
module qsp_master #(
   parameter int DATA_W = qsp_pkg::QSP_DATA_W,
   parameter int DEPTH  = qsp_pkg::QSP_FIFO_DEPTH
) (
   // clock and reset
   input  wire logic               sys_clk,
   input  wire logic               rst_n,
   // control and configuration
   input  wire qsp_pkg::qsp_mode_t mode_reg,
   input  wire logic               rx_direction,
   input  wire logic               channel_enable,
   input  wire logic               soft_reset_bit,
   input  wire logic               master_select_out,
   input  wire logic               timer_tick,
   input  wire qsp_pkg::qsp_mmap_t mmap_cfg,
   input  wire logic               mmap_cfg_wr,
   output qsp_pkg::qsp_mmap_t      mmap_cfg_q,
   // transmit and receive words
   input  wire logic               tx_wr,
   input  wire logic [DATA_W-1:0]  tx_data_reg,
   output logic                    tx_wr_ready,
   output logic      [DATA_W-1:0]  rx_data_reg,
   // flags and interrupt request
   input  wire qsp_pkg::qsp_flags_t irq_enable_reg,
   input  wire qsp_pkg::qsp_flags_t flag_clr,
   output qsp_pkg::qsp_flags_t     irq_flag_reg,
   output logic                    irq_q,
   // dma requests
   input  wire logic               tx_empty_dma_en,
   input  wire logic               rx_full_dma_en,
   input  wire logic               third_dma_en,
   output logic                    tx_dma_req_q,
   output logic                    rx_dma_req_q,
   output logic                    third_dma_req_q,
   // serial pins
   output logic                    serial_clock_pin,
   output logic                    select_n_pin,
   output logic                    pull_en_pin,
   output logic      [3:0]         serial_data_pins_o,
   output logic      [3:0]         serial_data_pins_oe,
   input  wire logic [3:0]         serial_data_pins_i
);
   import qsp_pkg::*;

   if (DATA_W < 4 || DATA_W > 64)
   begin : g_chk
      $error("data width must be 4 to 64");
   end

   qsp_state_t       state_q;
   qsp_flags_t       flags_d;
   logic             half_q;
   logic [4:0]       cnt_q;
   logic [DATA_W-1:0] tx_sh_q;
   logic [DATA_W-1:0] rx_sh_q;
   logic [DATA_W-1:0] rx_next;
   logic [DATA_W-1:0] rx_word;
   logic [DATA_W-1:0] f_data;
   logic [DATA_W-1:0] ld_word;
   logic [3:0]       din_s1_q;
   logic [3:0]       din_s2_q;
   logic             f_valid;
   logic             take;
   logic             f_pop;
   logic             abort;
   logic             active;
   logic             tick;
   logic             lead;
   logic             trail;
   logic             word_done;
   logic             drive_ev;
   logic             sample_ev;
   logic             single;
   logic             rx_en;
   logic             run_d;
   logic [2:0]       lanes;
   logic [6:0]       bits;
   logic [3:0]       oe_mask;
   logic             set_txe;
   logic             set_end;
   logic             set_rxf;
   logic             set_ovr;

   // ==========================================================
   // input synchronisers
   always_ff @(posedge sys_clk or negedge rst_n)
   begin
      if (!rst_n)
      begin
         din_s1_q <= '0;
         din_s2_q <= '0;
      end
      else
      begin
         din_s1_q <= serial_data_pins_i;
         din_s2_q <= din_s1_q;
      end
   end

   // ==========================================================
   // transmit fifo
   qsp_fifo #(.WIDTH(DATA_W), .DEPTH(DEPTH)) u_fifo (
      .clk       (sys_clk),
      .rst_n     (rst_n),
      .flush     (soft_reset_bit),
      .in_valid  (tx_wr),
      .in_ready  (tx_wr_ready),
      .in_data   (tx_data_reg),
      .out_valid (f_valid),
      .out_ready (take),
      .out_data  (f_data)
   );

   // ==========================================================
   // sequencing terms
   // timer clock sets the half period unless no-divide is chosen
   assign tick      = mode_reg.master_clock_nodivide | timer_tick;
   assign abort     = soft_reset_bit | ~channel_enable;
   assign active    = mode_reg.master_select & ~abort;
   assign lead      = (state_q == QSP_ST_RUN) & tick & ~half_q;
   assign trail     = (state_q == QSP_ST_RUN) & tick & half_q;
   assign word_done = trail & (cnt_q == {1'b0, mode_reg.char_clock_count});
   assign take      = active & ((state_q == QSP_ST_IDLE) | word_done);
   assign f_pop     = take & f_valid;
   assign run_d     = ~abort & (f_pop | ((state_q == QSP_ST_RUN) & ~word_done));
   assign single    = (mode_reg.line_count_mode == QSP_LINES_SINGLE);
   // direction only matters with several lines
   assign rx_en     = single | rx_direction;
   assign drive_ev  = mode_reg.clock_phase_sel ? lead : (trail & ~word_done);
   assign sample_ev = mode_reg.clock_phase_sel ? trail : lead;
   assign lanes     = single ? 3'h1 :
                      (mode_reg.line_count_mode == QSP_LINES_DUAL) ? 3'h2 : 3'h4;
   // widen before the product, sixteen quad clocks give 64 bits
   assign bits      = 7'(cnt_q + 5'h01) * 7'(lanes);
   assign oe_mask   = (single) ? QSP_OE_SINGLE :
                      (rx_direction) ? QSP_OE_NONE :
                      (mode_reg.line_count_mode == QSP_LINES_DUAL) ? QSP_OE_DUAL : QSP_OE_QUAD;

   function automatic logic [3:0] out_bits(input logic [DATA_W-1:0] sh, input logic lsb,
                                           input logic [2:0] ln);
      logic [3:0] r;
      r = '0;
      if (lsb)
         r = (ln == 3'h1) ? {3'h0, sh[0]} : (ln == 3'h2) ? {2'h0, sh[1:0]} : sh[3:0];
      else
         r = (ln == 3'h1) ? {3'h0, sh[DATA_W-1]} :
             (ln == 3'h2) ? {2'h0, sh[DATA_W-1 -: 2]} : sh[DATA_W-1 -: 4];
      return r;
   endfunction

   function automatic logic [DATA_W-1:0] shifted(input logic [DATA_W-1:0] sh,
                                                 input logic lsb, input logic [2:0] ln);
      return lsb ? (sh >> ln) : (sh << ln);
   endfunction

   // receive shift-in, line order mirrors the transmit side
   always_comb
   begin
      rx_next = rx_sh_q;
      if (sample_ev)
      begin
         unique case (lanes)
            3'h1:    rx_next = mode_reg.low_bit_first ? {din_s2_q[1], rx_sh_q[DATA_W-1:1]}
                                                      : {rx_sh_q[DATA_W-2:0], din_s2_q[1]};
            3'h2:    rx_next = mode_reg.low_bit_first ? {din_s2_q[1:0], rx_sh_q[DATA_W-1:2]}
                                                      : {rx_sh_q[DATA_W-3:0], din_s2_q[1:0]};
            default: rx_next = mode_reg.low_bit_first ? {din_s2_q[3:0], rx_sh_q[DATA_W-1:4]}
                                                      : {rx_sh_q[DATA_W-5:0], din_s2_q[3:0]};
         endcase
      end
      // short low-first words sit at the top and must be brought down
      rx_word = rx_next;
      if (mode_reg.low_bit_first && (32'(bits) < DATA_W))
         rx_word = rx_next >> (DATA_W - 32'(bits));
   end

   // ==========================================================
   // shift engine
   assign ld_word = f_data;

   always_ff @(posedge sys_clk or negedge rst_n)
   begin
      if (!rst_n)
      begin
         state_q            <= QSP_ST_IDLE;
         half_q             <= 1'b0;
         cnt_q              <= QSP_CNT_RST;
         tx_sh_q            <= '0;
         rx_sh_q            <= '0;
         serial_clock_pin   <= 1'b0;
         serial_data_pins_o <= '0;
      end
      else if (abort)
      begin
         // partial word is dropped and the clock parks at idle level
         state_q            <= QSP_ST_IDLE;
         half_q             <= 1'b0;
         cnt_q              <= QSP_CNT_RST;
         tx_sh_q            <= '0;
         rx_sh_q            <= '0;
         serial_clock_pin   <= mode_reg.clock_polarity_sel;
         serial_data_pins_o <= '0;
      end
      else if (f_pop)
      begin
         state_q  <= QSP_ST_RUN;
         half_q   <= 1'b0;
         cnt_q    <= QSP_CNT_RST;
         rx_sh_q  <= '0;
         serial_clock_pin <= mode_reg.clock_polarity_sel;
         // phase 0 presents the first bits before the leading edge
         if (!mode_reg.clock_phase_sel)
         begin
            serial_data_pins_o <= rx_en & ~single ? '0 :
                                  out_bits(ld_word, mode_reg.low_bit_first, lanes);
            tx_sh_q <= shifted(ld_word, mode_reg.low_bit_first, lanes);
         end
         else
            tx_sh_q <= ld_word;
      end
      else
      begin
         if (word_done)
            state_q <= QSP_ST_IDLE;
         if (lead)
         begin
            half_q           <= 1'b1;
            serial_clock_pin <= ~mode_reg.clock_polarity_sel;
         end
         if (trail)
         begin
            half_q           <= 1'b0;
            cnt_q            <= cnt_q + 5'h01;
            serial_clock_pin <= mode_reg.clock_polarity_sel;
         end
         if (state_q == QSP_ST_IDLE)
            serial_clock_pin <= mode_reg.clock_polarity_sel;
         if (drive_ev)
         begin
            // receive in dual or quad drives nothing
            serial_data_pins_o <= rx_en & ~single ? '0 :
                                  out_bits(tx_sh_q, mode_reg.low_bit_first, lanes);
            tx_sh_q <= shifted(tx_sh_q, mode_reg.low_bit_first, lanes);
         end
         rx_sh_q <= rx_next;
      end
   end

   always_ff @(posedge sys_clk or negedge rst_n)
   begin
      if (!rst_n)
         serial_data_pins_oe <= QSP_OE_NONE;
      else
         serial_data_pins_oe <= run_d ? oe_mask : QSP_OE_NONE;
   end

   // ==========================================================
   // receive buffer
   always_ff @(posedge sys_clk or negedge rst_n)
   begin
      if (!rst_n)
         rx_data_reg <= '0;
      else if (word_done & rx_en & ~abort)
         rx_data_reg <= rx_word;
   end

   // ==========================================================
   // flags, set wins over clear
   assign set_txe = f_pop;
   assign set_end = word_done & ~f_pop & ~abort;
   assign set_rxf = word_done & rx_en & ~abort;
   assign set_ovr = set_rxf & irq_flag_reg.rx_full;

   always_comb
   begin
      flags_d.tx_empty = set_txe | (irq_flag_reg.tx_empty & ~flag_clr.tx_empty);
      flags_d.tx_end   = set_end | (irq_flag_reg.tx_end & ~flag_clr.tx_end);
      flags_d.rx_full  = set_rxf | (irq_flag_reg.rx_full & ~flag_clr.rx_full);
      flags_d.overrun  = set_ovr | (irq_flag_reg.overrun & ~flag_clr.overrun);
      if (soft_reset_bit)
         flags_d = '{QSP_TX_EMPTY_RST, QSP_FLAG_RST, QSP_FLAG_RST, QSP_FLAG_RST};
   end

   always_ff @(posedge sys_clk or negedge rst_n)
   begin
      if (!rst_n)
      begin
         irq_flag_reg <= '{QSP_TX_EMPTY_RST, QSP_FLAG_RST, QSP_FLAG_RST, QSP_FLAG_RST};
         irq_q        <= 1'b0;
      end
      else
      begin
         irq_flag_reg <= flags_d;
         irq_q        <= |(flags_d & irq_enable_reg);
      end
   end

   // ==========================================================
   // dma requests, one pulse per event
   always_ff @(posedge sys_clk or negedge rst_n)
   begin
      if (!rst_n)
      begin
         tx_dma_req_q    <= 1'b0;
         rx_dma_req_q    <= 1'b0;
         third_dma_req_q <= 1'b0;
      end
      else
      begin
         tx_dma_req_q    <= tx_empty_dma_en & set_txe;
         rx_dma_req_q    <= rx_full_dma_en & set_rxf;
         third_dma_req_q <= third_dma_en & set_end;
      end
   end

   // ==========================================================
   // pins and held configuration
   always_ff @(posedge sys_clk or negedge rst_n)
   begin
      if (!rst_n)
      begin
         select_n_pin <= 1'b1;
         pull_en_pin  <= 1'b0;
         mmap_cfg_q   <= '0;
      end
      else
      begin
         select_n_pin <= ~(master_select_out & active);
         pull_en_pin  <= mode_reg.input_pull_enable;
         if (mmap_cfg_wr)
            mmap_cfg_q <= mmap_cfg;
      end
   end

   // ==========================================================
   // assertions
   default clocking cb @(posedge sys_clk); endclocking
   default disable iff (!rst_n);

   start_run_a: assert property (f_pop && !abort |=> state_q == QSP_ST_RUN)
      else $error("taken word did not start a transfer");
   tx_empty_set_a: assert property (f_pop && !soft_reset_bit |=> irq_flag_reg.tx_empty)
      else $error("tx empty not set on word move");
   gapless_word_a: assert property (word_done && f_pop && !abort
                                    |=> state_q == QSP_ST_RUN && cnt_q == 5'h00)
      else $error("next word not chained");
   tx_end_set_a: assert property (set_end && !soft_reset_bit
                                  |=> irq_flag_reg.tx_end && state_q == QSP_ST_IDLE)
      else $error("end of transmission not flagged");
   tx_dma_req_a: assert property (tx_empty_dma_en && set_txe |=> tx_dma_req_q)
      else $error("missing tx dma request");
   flag_clear_a: assert property (flag_clr.rx_full && !set_rxf && !soft_reset_bit
                                  |=> !irq_flag_reg.rx_full)
      else $error("rx full not cleared");
   rx_full_set_a: assert property (set_rxf && !soft_reset_bit
                                   |=> irq_flag_reg.rx_full && rx_data_reg == $past(rx_word))
      else $error("received word not buffered");
   overrun_set_a: assert property (set_rxf && irq_flag_reg.rx_full && !soft_reset_bit
                                   |=> irq_flag_reg.overrun)
      else $error("overrun not flagged");
   soft_reset_a: assert property (soft_reset_bit |=> state_q == QSP_ST_IDLE && select_n_pin
                                  && serial_clock_pin == $past(mode_reg.clock_polarity_sel))
      else $error("soft reset left channel active");
endmodule // qsp_master

// file: verif/qsp_slave_model.sv
// behavioural serial slave: records what the master sends, answers a fixed word
module qsp_slave_model #(
   parameter logic [7:0] REPLY = 8'h3c
) (
   // serial side
   input  wire logic        sclk,
   input  wire logic        sel_n,
   input  wire logic [3:0]  sdo,
   output logic      [3:0]  sdi,
   // observation
   output logic      [15:0] got,
   output logic      [15:0] got2,
   output int               edges
);
   timeunit 1ns;
   timeprecision 1ns;
   logic [7:0] rsh = REPLY;
   logic       tgl = 1'b0;
   initial {got, got2, edges} = '0;
   // ==========================================================
   // answer: reloaded at each select and rotated on each falling clock, so it repeats every 8 clocks
   always @(negedge sel_n) rsh = REPLY;
   always @(negedge sclk) if (!sel_n) rsh = {rsh[6:0], rsh[7]};
   // idle or unused lines keep changing, never the last value
   always @(sclk or sel_n) tgl = ~tgl;
   assign sdi = sel_n ? {4{tgl}} : {tgl, ~tgl, rsh[7], tgl};
   // ==========================================================
   // capture on the rising edge, phase 0 and polarity 0
   always @(posedge sclk)
      if (!sel_n)
      begin
         got   = {got[14:0], sdo[0]};
         got2  = {got2[13:0], sdo[1:0]};
         edges = edges + 1;
      end
endmodule // qsp_slave_model

// file: verif/qsp_master_bench.sv
// self-checking bench of the quad serial master channel
module qsp_master_bench;
   timeunit 1ns;
   timeprecision 1ns;
   import qsp_pkg::*;
   // ==========================================================
   // signals
   logic         sys_clk, rst_n, tx_wr, timer_tick, soft_reset_bit, channel_enable;
   logic         rx_direction, master_select_out, mmap_cfg_wr, irq_q, tx_wr_ready;
   logic         tx_dma_req_q, rx_dma_req_q, third_dma_req_q;
   logic         serial_clock_pin, select_n_pin, pull_en_pin;
   logic [2:0]   dma_en;
   logic [1:0]   tick_cnt;
   logic [15:0]  tx_data_reg, rx_data_reg, got, got2;
   logic [3:0]   sdo, sdo_oe, sdi;
   qsp_mode_t    mode;
   qsp_mmap_t    mmap_cfg, mmap_cfg_q;
   qsp_flags_t   irq_en, flag_clr, irq_flag_reg;
   int           edges, mismatches, total_checks, e0, n_dma[3];

   qsp_master u_dut (.sys_clk(sys_clk), .rst_n(rst_n), .mode_reg(mode),
      .rx_direction(rx_direction), .channel_enable(channel_enable),
      .soft_reset_bit(soft_reset_bit), .master_select_out(master_select_out),
      .timer_tick(timer_tick), .mmap_cfg(mmap_cfg), .mmap_cfg_wr(mmap_cfg_wr),
      .mmap_cfg_q(mmap_cfg_q), .tx_wr(tx_wr), .tx_data_reg(tx_data_reg),
      .tx_wr_ready(tx_wr_ready), .rx_data_reg(rx_data_reg), .irq_enable_reg(irq_en),
      .flag_clr(flag_clr), .irq_flag_reg(irq_flag_reg), .irq_q(irq_q),
      .tx_empty_dma_en(dma_en[0]), .rx_full_dma_en(dma_en[1]), .third_dma_en(dma_en[2]),
      .tx_dma_req_q(tx_dma_req_q), .rx_dma_req_q(rx_dma_req_q),
      .third_dma_req_q(third_dma_req_q), .serial_clock_pin(serial_clock_pin),
      .select_n_pin(select_n_pin), .pull_en_pin(pull_en_pin),
      .serial_data_pins_o(sdo), .serial_data_pins_oe(sdo_oe), .serial_data_pins_i(sdi));
   qsp_slave_model u_slave (.sclk(serial_clock_pin), .sel_n(select_n_pin), .sdo(sdo),
      .sdi(sdi), .got(got), .got2(got2), .edges(edges));

   // ==========================================================
   // clock, tick every third cycle so received bits survive the synchroniser
   initial
   begin
      sys_clk = 1'b0;
      forever #50 sys_clk = ~sys_clk;
   end
   always @(posedge sys_clk)
   begin
      tick_cnt   <= (tick_cnt == 2'd2) ? 2'd0 : tick_cnt + 2'd1;
      timer_tick <= (tick_cnt == 2'd1);
   end
   always @(negedge sys_clk)
   begin
      n_dma[0] += tx_dma_req_q;
      n_dma[1] += rx_dma_req_q;
      n_dma[2] += third_dma_req_q;
   end
   // ==========================================================
   // shared tasks
   task automatic chk(input string what, input logic [47:0] seen, input logic [47:0] exp);
      total_checks++;
      if (seen !== exp)
      begin
         mismatches++;
         $display("FAIL %s expected %h seen %h", what, exp, seen);
      end
   endtask
   task automatic end_of_test;
      $display("checks %0d mismatches %0d", total_checks, mismatches);
      if (mismatches == 0 && total_checks > 0)
         $display("STATUS OK");
      else
         $display("STATUS NOT OK");
      $finish;
   endtask
   task automatic cyc(input int n);
      repeat (n) @(posedge sys_clk);
      #1;
   endtask
   task automatic send(input logic [15:0] w);
      while (tx_wr_ready !== 1'b1) cyc(1);
      @(posedge sys_clk);
      tx_wr       <= 1'b1;
      tx_data_reg <= w;
      @(posedge sys_clk);
      tx_wr       <= 1'b0;
   endtask
   task automatic clr;
      @(posedge sys_clk);
      flag_clr <= 4'hf;
      @(posedge sys_clk);
      flag_clr <= 4'h0;
      e0 = edges;
   endtask
   task automatic wait_end;
      for (int n = 0; n < 800 && irq_flag_reg.tx_end !== 1'b1; n++) cyc(1);
      chk("end seen", irq_flag_reg.tx_end, 1'b1);
      cyc(4);
   endtask
   // ==========================================================
   // scenarios
   task automatic t_init;
      chk("reset flags", irq_flag_reg, 4'h8);
      irq_en <= 4'h8;
      cyc(3);
      chk("irq empty", irq_q, 1'b1);
      soft_reset_bit <= 1'b1;
      cyc(1);
      soft_reset_bit <= 1'b0;
      channel_enable <= 1'b1;
      master_select_out <= 1'b1;
      clr;
      cyc(2);
      chk("cleared", irq_flag_reg, 4'h0);
      chk("irq off", irq_q, 1'b0);
      chk("select", select_n_pin, 1'b0);
   endtask
   task automatic t_single;
      irq_en <= 4'h4;
      dma_en <= 3'b111;
      n_dma = '{0, 0, 0};
      send(16'ha500);
      wait_end;
      chk("clocks", edges - e0, 8);
      chk("sent", got[7:0], 8'ha5);
      chk("flags", irq_flag_reg, 4'he);
      chk("irq end", irq_q, 1'b1);
      chk("clk idle", serial_clock_pin, 1'b0);
      chk("rx word", rx_data_reg[7:0], 8'h3c);
      foreach (n_dma[i]) chk("dma", n_dma[i], 1);
   endtask
   task automatic t_b2b;
      clr;
      send(16'h5a00);
      send(16'hc300);
      wait_end;
      chk("gapless", edges - e0, 16);
      chk("sent2", got, 16'h5ac3);
      chk("overrun", irq_flag_reg, 4'hf);
      chk("rx over", rx_data_reg[7:0], 8'h3c);
   endtask
   task automatic t_dual;
      mode.line_count_mode <= QSP_LINES_DUAL;
      mode.char_clock_count <= 4'h3;
      clr;
      send(16'hb400);
      cyc(6);
      chk("dual oe", sdo_oe, QSP_OE_DUAL);
      wait_end;
      chk("dual clk", edges - e0, 4);
      chk("dual data", got2[7:0], 8'hb4);
      chk("dual flags", irq_flag_reg, 4'hc);
      rx_direction <= 1'b1;
      clr;
      send(16'h0000);
      cyc(6);
      chk("rx oe", sdo_oe, QSP_OE_NONE);
      wait_end;
      chk("rx flags", irq_flag_reg, 4'he);
      rx_direction <= 1'b0;
      mode.line_count_mode <= QSP_LINES_SINGLE;
      mode.char_clock_count <= 4'h7;
   endtask
   task automatic t_soft;
      clr;
      send(16'hff00);
      cyc(15);
      soft_reset_bit <= 1'b1;
      cyc(1);
      soft_reset_bit <= 1'b0;
      cyc(4);
      e0 = edges;
      cyc(60);
      chk("stopped", edges - e0, 0);
      chk("clk rest", serial_clock_pin, 1'b0);
      chk("soft flags", irq_flag_reg, 4'h8);
      clr;
      send(16'h8100);
      wait_end;
      chk("restart", got[7:0], 8'h81);
   endtask
   task automatic t_mmap;
      mmap_cfg <= 47'h5a5a_1234_c3e1;
      mmap_cfg_wr <= 1'b1;
      cyc(1);
      mmap_cfg_wr <= 1'b0;
      cyc(2);
      chk("mmap", mmap_cfg_q, 47'h5a5a_1234_c3e1);
      chk("pull", pull_en_pin, 1'b1);
   endtask
   // ==========================================================
   // main sequence and watchdog
   initial
   begin
      {rst_n, tx_wr, timer_tick, soft_reset_bit, channel_enable} = '0;
      {rx_direction, master_select_out, mmap_cfg_wr, dma_en, tick_cnt} = '0;
      {tx_data_reg, mmap_cfg, irq_en, flag_clr} = '0;
      mode = '0;
      mode.master_select = 1'b1;
      mode.input_pull_enable = 1'b1;
      mode.char_clock_count = 4'h7;
      {mismatches, total_checks, e0} = '0;
      repeat (5) @(posedge sys_clk);
      rst_n <= 1'b1;
      cyc(2);
      t_init;
      t_single;
      t_b2b;
      t_dual;
      t_soft;
      t_mmap;
      end_of_test;
   end
   initial
   begin
      #3_000_000;
      mismatches++;
      end_of_test;
   end
endmodule // qsp_master_bench
